// ### design/psl_latch_ctrl.sv
/*
 * Latch set of an integer-N synthesizer: control, N divider and
 * reference divider latches loaded from a 3-wire serial port, power-down
 * control, reference and N counters, lock detection and output gating.
 * Assumes pins arrive asynchronously; the serial clock is its own domain.
 */
// Functional notes
// [R1] Word shifted MSB first on serial clock; strobe rise loads latch by select.
// [R2] Select code 00 loads the control latch.
// [R3] Select code 10 loads the N divider latch.
// [R4] Host writes reference, then control, then N latch after power is applied.
// [R5] Host waits 5 ms or 600 us between control and N writes at power-up.
// [R6] Power-down enable with mode zero powers down at once.
// [R7] Power-down enable with mode one waits two reference divider edges.
// [R8] Enable pin low disables the device regardless of power-down bits.
// [R9] Power-down loads counters, tristates pump, resets lock, mutes RF, ref buffer.
// [R10] Serial input and strobes keep working during power-down.
// [R11] Host must not change N latch in power-down, else redo sequence.
// [R12] Leaving power-down with N unchanged keeps band; no band reselect.
// [R13] Mute-until-lock keeps RF outputs off until lock is detected.
// [R14] Pump gain one selects current two, zero selects current one.
// [R15] Pump gain follows the latest write through control or N latch.
// [R16] Current one from lower three bits, current two from upper three.
// [R17] Pump tristate bit one forces the charge pump to three-state.
// [R18] Polarity bit one positive, zero negative.
// [R19] Counter clear bit holds reference and N counters in reset.
// [R20] N latch holds 5-bit swallow count, 0 through 31.
// [R21] N latch holds 13-bit main count, valid 3 through 8191.
// [R22] Host writes zero into the N latch spare bit.
// [R23] Host sets core bias to 15 mA above 2 GHz, 20 mA below.
// [R24] 14-bit reference divider sets ratio 1 through 16383.
// [R25] Lock window bit: five good cycles when one, three when zero.
// [R26] Shifting alone changes no latch; only the strobe transfers.
`timescale 1ns/100ps
`default_nettype none
module psl_latch_ctrl
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        serial_clk,
   input  wire logic        serial_data,
   input  wire logic        latch_strobe,
   input  wire logic        chip_enable,
   input  wire logic        ref_in,
   input  wire logic        fb_in,
   input  wire logic        phase_err_small,
   input  wire logic        phase_err_large,
   output logic             powered_down,
   output logic             counters_held,
   output logic             pump_tristate,
   output logic      [2:0]  pump_current,
   output logic             pump_polarity,
   output logic             rf_output_enable,
   output logic             ref_buffer_enable,
   output logic             lock_detect,
   output logic             ref_div_pulse,
   output logic             n_div_pulse,
   output logic             prescale_modulus,
   output logic             band_select_start,
   output logic             main_count_invalid,
   output logic      [1:0]  prescale_select_bits,
   output logic      [1:0]  core_bias_bits,
   output logic      [2:0]  mux_select_bits,
   output logic      [1:0]  output_level_bits,
   output logic             div2_enable,
   output logic             div2_select,
   output logic      [1:0]  pulse_width_bits,
   output logic      [1:0]  band_clock_div_bits,
   output logic             factory_test_bit
);
   localparam int W    = psl_pkg::WORD_W;
   localparam int NSYN = 6;
   // Sync vector positions
   localparam int S_STROBE = 0;
   localparam int S_CE     = 1;
   localparam int S_REF    = 2;
   localparam int S_FB     = 3;
   localparam int S_SMALL  = 4;
   localparam int S_LARGE  = 5;

   logic [W-1:0]      shift_word;
   logic [NSYN-1:0]   pin_raw;
   logic [NSYN-1:0]   sync_a;
   logic [NSYN-1:0]   sync_b;
   logic [NSYN-1:0]   sync_prev;
   logic              strobe_rise;
   logic              ref_rise;
   logic              fb_rise;
   logic [W-1:0]      control_latch;
   logic [W-1:0]      ndiv_latch;
   logic [W-1:0]      reference_divider_latch;
   logic              pump_gain;
   logic              wr_control;
   logic              wr_ndiv;
   logic              wr_ref;
   psl_pkg::psl_pwr_e pwr_state;
   psl_pkg::psl_pwr_e next_pwr_state;
   logic [1:0]        pd_edges;
   logic              pd_any;
   logic              hold;
   logic [psl_pkg::REFDIV_W-1:0]  ref_cnt;
   logic [psl_pkg::REFDIV_W-1:0]  ref_ratio;
   logic [psl_pkg::SWALLOW_W-1:0] swallow_cnt;
   logic [psl_pkg::MAIN_W-1:0]    main_cnt;
   logic [psl_pkg::MAIN_W-1:0]    main_val;
   logic [2:0]        lock_cnt;
   logic [2:0]        lock_need;
   logic              locked;
   logic              ref_tick;

   // Serial shift register on the host's clock
   psl_shift_in #(.W(W)) u_shift
   (
      .serial_clk  (serial_clk),
      .serial_data (serial_data),
      .word        (shift_word)
   ); // [R1]

   assign pin_raw = {phase_err_large, phase_err_small, fb_in, ref_in,
                     chip_enable, latch_strobe};

   // Three flops per asynchronous pin; edges compare the second stage with the third
   genvar gi;
   generate
      for (gi = 0; gi < NSYN; gi++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (sys_rst)
            begin
               sync_a[gi]    <= 1'b0;
               sync_b[gi]    <= 1'b0;
               sync_prev[gi] <= 1'b0;
            end
            else
            begin
               sync_a[gi]    <= pin_raw[gi];
               sync_b[gi]    <= sync_a[gi];
               sync_prev[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   assign strobe_rise = sync_b[S_STROBE] & ~sync_prev[S_STROBE];
   assign ref_rise    = sync_b[S_REF] & ~sync_prev[S_REF];
   assign fb_rise     = sync_b[S_FB] & ~sync_prev[S_FB];

   // The shifted word is only copied on the strobe edge; it is quiet by then
   // because the serial clock idles while the strobe is high.
   assign wr_control = strobe_rise &
      (shift_word[psl_pkg::SEL_LSB +: psl_pkg::SEL_W] ==
       psl_pkg::SEL_CONTROL); // [R2]
   assign wr_ndiv = strobe_rise &
      (shift_word[psl_pkg::SEL_LSB +: psl_pkg::SEL_W] ==
       psl_pkg::SEL_NDIV); // [R3]
   assign wr_ref = strobe_rise &
      (shift_word[psl_pkg::SEL_LSB +: psl_pkg::SEL_W] ==
       psl_pkg::SEL_REF);

   // Latches load regardless of power state; test latch code is ignored
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         control_latch           <= psl_pkg::LATCH_RST;
         ndiv_latch              <= psl_pkg::LATCH_RST;
         reference_divider_latch <= psl_pkg::LATCH_RST;
      end
      else
      begin
         if (wr_control)
            control_latch <= shift_word; // [R10] [R26]
         if (wr_ndiv)
            ndiv_latch <= shift_word; // [R10] [R26]
         if (wr_ref)
            reference_divider_latch <= shift_word; // [R10] [R26]
      end
   end

   // One shared gain flop, written from either latch
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pump_gain <= psl_pkg::GAIN_RST;
      else if (wr_control)
         pump_gain <= shift_word[psl_pkg::CTL_GAIN_BIT]; // [R15]
      else if (wr_ndiv)
         pump_gain <= shift_word[psl_pkg::N_GAIN_BIT]; // [R15]
   end

   // Power-down sequencing
   always_comb
   begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         psl_pkg::PSL_PWR_ON:
            next_pwr_state = psl_pkg::PSL_PWR_ON;
         psl_pkg::PSL_PWR_WAIT:
            if (ref_tick && pd_edges == psl_pkg::PD_SYNC_EDGES - 2'h1)
               next_pwr_state = psl_pkg::PSL_PWR_DOWN; // [R7]
         psl_pkg::PSL_PWR_DOWN:
            next_pwr_state = psl_pkg::PSL_PWR_DOWN;
         default:
            next_pwr_state = psl_pkg::PSL_PWR_ON;
      endcase
      // A fresh control write overrides whatever was pending
      if (wr_control)
      begin
         if (!shift_word[psl_pkg::PD_EN_BIT])
            next_pwr_state = psl_pkg::PSL_PWR_ON;
         else if (!shift_word[psl_pkg::PD_MODE_BIT])
            next_pwr_state = psl_pkg::PSL_PWR_DOWN; // [R6]
         else if (pwr_state != psl_pkg::PSL_PWR_DOWN)
            next_pwr_state = psl_pkg::PSL_PWR_WAIT; // [R7]
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pwr_state <= psl_pkg::PSL_PWR_ON;
      else
         pwr_state <= next_pwr_state;
   end

   // Reference divider ticks seen since the strobe that armed synchronous mode
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pd_edges <= 2'h0;
      else if (wr_control || pwr_state != psl_pkg::PSL_PWR_WAIT)
         pd_edges <= 2'h0;
      else if (ref_tick)
         pd_edges <= pd_edges + 2'h1; // [R7]
   end

   assign pd_any = (pwr_state == psl_pkg::PSL_PWR_DOWN) |
                   ~sync_b[S_CE]; // [R8]
   assign hold   = pd_any | control_latch[psl_pkg::CLEAR_BIT]; // [R9] [R19]

   // Reference divider; ratio 0 behaves as 1
   assign ref_ratio =
      reference_divider_latch[psl_pkg::REFDIV_LSB +: psl_pkg::REFDIV_W];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ref_cnt  <= '0;
         ref_tick <= 1'b0;
      end
      else if (hold)
      begin
         ref_cnt  <= ref_ratio; // [R9] [R19]
         ref_tick <= 1'b0;
      end
      else if (ref_rise)
      begin
         if (ref_cnt <= 14'h0001)
         begin
            ref_cnt  <= ref_ratio; // [R24]
            ref_tick <= 1'b1;
         end
         else
         begin
            ref_cnt  <= ref_cnt - 14'h0001;
            ref_tick <= 1'b0;
         end
      end
      else
         ref_tick <= 1'b0;
   end

   // Swallow and main counters on prescaler output edges
   assign main_val = ndiv_latch[psl_pkg::MAIN_LSB +: psl_pkg::MAIN_W];

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         swallow_cnt <= '0;
         main_cnt    <= '0;
         n_div_pulse <= 1'b0;
      end
      else if (hold)
      begin
         swallow_cnt <= ndiv_latch[psl_pkg::SWALLOW_LSB +:
                                   psl_pkg::SWALLOW_W]; // [R9] [R19]
         main_cnt    <= main_val;
         n_div_pulse <= 1'b0;
      end
      else if (fb_rise)
      begin
         if (main_cnt <= 13'h0001)
         begin
            swallow_cnt <= ndiv_latch[psl_pkg::SWALLOW_LSB +:
                                      psl_pkg::SWALLOW_W]; // [R20]
            main_cnt    <= main_val; // [R21]
            n_div_pulse <= 1'b1;
         end
         else
         begin
            if (swallow_cnt != '0)
               swallow_cnt <= swallow_cnt - 5'h01;
            main_cnt    <= main_cnt - 13'h0001;
            n_div_pulse <= 1'b0;
         end
      end
      else
         n_div_pulse <= 1'b0;
   end

   // Lock detection, judged once per reference divider cycle
   assign lock_need = reference_divider_latch[psl_pkg::LOCK_WIN_BIT] ?
                      psl_pkg::LOCK_LONG : psl_pkg::LOCK_SHORT; // [R25]

   always_ff @(posedge clk)
   begin
      if (sys_rst || pd_any)
      begin
         lock_cnt <= 3'h0; // [R9]
         locked   <= 1'b0;
      end
      else if (ref_tick)
      begin
         if (sync_b[S_LARGE])
         begin
            lock_cnt <= 3'h0;
            locked   <= 1'b0;
         end
         else if (sync_b[S_SMALL])
         begin
            if (lock_cnt < lock_need)
               lock_cnt <= lock_cnt + 3'h1;
            if (lock_cnt + 3'h1 >= lock_need)
               locked <= 1'b1; // [R25]
         end
         else
            lock_cnt <= 3'h0;
      end
   end

   // Registered status outputs
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         powered_down       <= 1'b0;
         counters_held      <= 1'b0;
         pump_tristate      <= 1'b0;
         pump_current       <= 3'h0;
         pump_polarity      <= 1'b0;
         rf_output_enable   <= 1'b0;
         ref_buffer_enable  <= 1'b0;
         lock_detect        <= 1'b0;
         ref_div_pulse      <= 1'b0;
         prescale_modulus   <= 1'b0;
         band_select_start  <= 1'b0;
         main_count_invalid <= 1'b0;
      end
      else
      begin
         powered_down      <= pd_any; // [R8]
         counters_held     <= hold;
         pump_tristate     <= pd_any |
                              control_latch[psl_pkg::TRISTATE_BIT]; // [R17]
         pump_current      <= pump_gain ?
            control_latch[psl_pkg::CUR2_LSB +: psl_pkg::CUR_W] :
            control_latch[psl_pkg::CUR1_LSB +: psl_pkg::CUR_W]; // [R14] [R16]
         pump_polarity     <= control_latch[psl_pkg::POLARITY_BIT]; // [R18]
         rf_output_enable  <= ~pd_any &
            (~control_latch[psl_pkg::MUTE_BIT] | locked); // [R9] [R13]
         ref_buffer_enable <= ~pd_any; // [R9]
         lock_detect       <= locked;
         ref_div_pulse     <= ref_tick;
         prescale_modulus  <= ~hold & (swallow_cnt != '0);
         // Band selection only follows an N latch write, never a power-up
         band_select_start <= wr_ndiv; // [R12]
         main_count_invalid <= main_val < psl_pkg::MAIN_MIN; // [R21]
      end
   end

   // Field outputs straight from the latch flops
   assign prescale_select_bits =
      control_latch[psl_pkg::PRESCALE_LSB +: psl_pkg::PRESCALE_W];
   assign core_bias_bits =
      control_latch[psl_pkg::CORE_BIAS_LSB +: psl_pkg::CORE_BIAS_W];
   assign mux_select_bits   =
      control_latch[psl_pkg::MUX_LSB +: psl_pkg::MUX_W];
   assign output_level_bits =
      control_latch[psl_pkg::LEVEL_LSB +: psl_pkg::LEVEL_W];
   assign div2_enable       = ndiv_latch[psl_pkg::DIV2_BIT];
   assign div2_select       = ndiv_latch[psl_pkg::DIV2_SEL_BIT];
   assign pulse_width_bits  =
      reference_divider_latch[psl_pkg::PULSE_LSB +: psl_pkg::PULSE_W];
   assign band_clock_div_bits =
      reference_divider_latch[psl_pkg::BAND_DIV_LSB +: psl_pkg::BAND_DIV_W];
   assign factory_test_bit  = reference_divider_latch[psl_pkg::TEST_BIT];
endmodule : psl_latch_ctrl
`default_nettype wire

// ### design/psl_shift_in.sv
/*
 * Serial input shift register, clocked by the host's serial clock.
 * Assumes the host stops the serial clock while the latch strobe is
 * high, so the word stays still while the system clock side copies it.
 */
`timescale 1ns/100ps
`default_nettype none
module psl_shift_in
#(
   parameter int W = psl_pkg::WORD_W
)
(
   input  wire logic         serial_clk,
   input  wire logic         serial_data,
   output logic     [W-1:0]  word
);
   // No reset: the serial clock may stand still, and nothing is taken
   // from here except on a strobe edge.
   always_ff @(posedge serial_clk)
   begin
      word <= {word[W-2:0], serial_data};
   end
endmodule : psl_shift_in
`default_nettype wire

// ### pkg/psl_pkg.sv
/*
 * Constants for the serially programmed latch set of the synthesizer:
 * latch select codes, field positions and widths, reset values, lock
 * window lengths and the power-down state encoding.
 * Assumes the 24-bit word layout with the two select bits in the LSBs.
 */
package psl_pkg;
   localparam int WORD_W = 24;

   // Latch select field and its codes
   localparam int       SEL_LSB     = 0;
   localparam int       SEL_W       = 2;
   localparam bit [1:0] SEL_CONTROL = 2'h0;
   localparam bit [1:0] SEL_REF     = 2'h1;
   localparam bit [1:0] SEL_NDIV    = 2'h2;
   localparam bit [1:0] SEL_TEST    = 2'h3;

   // Control latch fields
   localparam int CORE_BIAS_LSB = 2;
   localparam int CORE_BIAS_W   = 2;
   localparam int CLEAR_BIT     = 4;
   localparam int MUX_LSB       = 5;
   localparam int MUX_W         = 3;
   localparam int POLARITY_BIT  = 8;
   localparam int TRISTATE_BIT  = 9;
   localparam int CTL_GAIN_BIT  = 10;
   localparam int MUTE_BIT      = 11;
   localparam int LEVEL_LSB     = 12;
   localparam int LEVEL_W       = 2;
   localparam int CUR1_LSB      = 14;
   localparam int CUR2_LSB      = 17;
   localparam int CUR_W         = 3;
   localparam int PD_EN_BIT     = 20;
   localparam int PD_MODE_BIT   = 21;
   localparam int PRESCALE_LSB  = 22;
   localparam int PRESCALE_W    = 2;

   // N divider latch fields
   localparam int SWALLOW_LSB   = 2;
   localparam int SWALLOW_W     = 5;
   localparam int SPARE_BIT     = 7;
   localparam int MAIN_LSB      = 8;
   localparam int MAIN_W        = 13;
   localparam int N_GAIN_BIT    = 21;
   localparam int DIV2_BIT      = 22;
   localparam int DIV2_SEL_BIT  = 23;

   // Reference divider latch fields
   localparam int REFDIV_LSB    = 2;
   localparam int REFDIV_W      = 14;
   localparam int PULSE_LSB     = 16;
   localparam int PULSE_W       = 2;
   localparam int LOCK_WIN_BIT  = 18;
   localparam int TEST_BIT      = 19;
   localparam int BAND_DIV_LSB  = 20;
   localparam int BAND_DIV_W    = 2;

   // Reset values and limits
   localparam bit [WORD_W-1:0] LATCH_RST    = 24'h000000;
   localparam bit              GAIN_RST     = 1'b0;
   localparam bit [MAIN_W-1:0] MAIN_MIN     = 13'h0003;
   localparam bit [2:0]        LOCK_SHORT   = 3'h3;
   localparam bit [2:0]        LOCK_LONG    = 3'h5;
   localparam bit [1:0]        PD_SYNC_EDGES = 2'h2;

   typedef enum logic [1:0] {
      PSL_PWR_ON   = 2'b00,
      PSL_PWR_WAIT = 2'b01,
      PSL_PWR_DOWN = 2'b10
   } psl_pwr_e;
endpackage : psl_pkg

// ### tb/psl_host_model.sv
/* Host side of the 3-wire latch port: shifts 24-bit words and strobes.
   Assumes it runs on its own link timing, unrelated to the system clock. */
`timescale 1ns/100ps
`default_nettype none
module psl_host_model
(
   output var logic serial_clk,
   output var logic serial_data,
   output var logic latch_strobe
);
   initial
   begin
      serial_clk   = 1'b0;
      serial_data  = 1'b0;
      latch_strobe = 1'b0;
   end

   // Serial clock runs only inside a frame, 160 ns period
   task automatic send(input logic [23:0] w, input logic strobe);
      #3.3;
      for (int i = 23; i >= 0; i--)
      begin
         serial_data = w[i];
         #80;
         serial_clk = 1'b1;
         #80;
         serial_clk = 1'b0;
      end
      // A released line must not keep showing the last bit
      serial_data = ~w[0];
      #60;
      latch_strobe = strobe;
      #100;
      latch_strobe = 1'b0;
      #60;
   endtask : send
endmodule : psl_host_model
`default_nettype wire

// ### tb/psl_latch_ctrl_checker.sv
/* Concurrent checks on the latch set's ports.
   Assumes binding to psl_latch_ctrl; one clock domain, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module psl_latch_ctrl_checker
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic latch_strobe,
   input wire logic chip_enable,
   input wire logic powered_down,
   input wire logic counters_held,
   input wire logic pump_tristate,
   input wire logic pump_polarity,
   input wire logic rf_output_enable,
   input wire logic ref_buffer_enable,
   input wire logic lock_detect,
   input wire logic ref_div_pulse,
   input wire logic n_div_pulse,
   input wire logic band_select_start
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   pin_disable_a:
      assert property (!chip_enable [*5] |-> powered_down)
      else $error("enable pin low without power-down");
   down_effects_a:
      assert property (powered_down [*2] |-> pump_tristate && counters_held
         && !rf_output_enable && !ref_buffer_enable && !lock_detect)
      else $error("power-down left a block active");
   ref_single_a:
      assert property (ref_div_pulse |=> !ref_div_pulse)
      else $error("reference pulse longer than one cycle");
   n_single_a:
      assert property (n_div_pulse |=> !n_div_pulse)
      else $error("divider pulse longer than one cycle");
   held_quiet_a:
      assert property (counters_held [*3] |-> !ref_div_pulse && !n_div_pulse)
      else $error("held counters still pulse");
   band_once_a:
      assert property (band_select_start |=> !band_select_start)
      else $error("band start longer than one cycle");
   band_cause_a:
      assert property (band_select_start |-> $past(latch_strobe, 2))
      else $error("band start without a strobe");
   polarity_cause_a:
      assert property ($changed(pump_polarity) |-> $past(latch_strobe, 2))
      else $error("polarity changed without a strobe");
endmodule : psl_latch_ctrl_checker

bind psl_latch_ctrl psl_latch_ctrl_checker i_psl_latch_ctrl_checker (.clk,
   .sys_rst, .latch_strobe, .chip_enable, .powered_down, .counters_held,
   .pump_tristate, .pump_polarity, .rf_output_enable, .ref_buffer_enable,
   .lock_detect, .ref_div_pulse, .n_div_pulse, .band_select_start);
`default_nettype wire

// ### tb/tb_psl_latch_ctrl.sv
/* Self-checking bench for the latch set, driven through the host model.
   Assumes the design needs about four clocks to apply a strobed word. */
`timescale 1ns/100ps
`default_nettype none
module tb_psl_latch_ctrl;
   localparam logic [23:0] REF_W = 24'h1a0009;
   localparam logic [23:0] CTL_W = 24'h4ce1ac;
   localparam logic [23:0] N_W   = 24'h600316;
   logic       clk, sys_rst, chip_enable, ref_in, fb_in;
   logic       phase_err_small, phase_err_large;
   wire logic  serial_clk, serial_data, latch_strobe;
   logic       powered_down, counters_held, pump_tristate, pump_polarity;
   logic       rf_output_enable, ref_buffer_enable, lock_detect;
   logic       ref_div_pulse, band_select_start, main_count_invalid;
   logic       n_div_pulse, prescale_modulus;
   logic       div2_enable, div2_select, factory_test_bit;
   logic [2:0] pump_current, mux_select_bits;
   logic [1:0] prescale_select_bits, core_bias_bits, output_level_bits;
   logic [1:0] pulse_width_bits, band_clock_div_bits;
   int         failures = 0;
   int         comparisons = 0;
   int         refs = 0;
   int         bands = 0;
   int         ns = 0;

   psl_host_model i_psl_host_model (.serial_clk, .serial_data,
      .latch_strobe);
   psl_latch_ctrl i_psl_latch_ctrl (.clk, .sys_rst, .serial_clk,
      .serial_data, .latch_strobe, .chip_enable, .ref_in, .fb_in,
      .phase_err_small, .phase_err_large, .powered_down, .counters_held,
      .pump_tristate, .pump_current, .pump_polarity, .rf_output_enable,
      .ref_buffer_enable, .lock_detect, .ref_div_pulse, .n_div_pulse,
      .prescale_modulus, .band_select_start, .main_count_invalid,
      .prescale_select_bits, .core_bias_bits, .mux_select_bits,
      .output_level_bits, .div2_enable, .div2_select, .pulse_width_bits,
      .band_clock_div_bits, .factory_test_bit);

   initial clk = 1'b0;
   always #5 clk = ~clk;

   always @(posedge clk)
   begin
      if (ref_div_pulse === 1'b1) refs <= refs + 1;
      if (band_select_start === 1'b1) bands <= bands + 1;
      if (n_div_pulse === 1'b1) ns <= ns + 1;
   end

   task chk(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [23:0] w);
      i_psl_host_model.send(w, 1'b1);
      @(negedge clk);
   endtask : wr

   // With a ratio of 2, two rising reference edges give exactly one tick
   task tick;
      repeat (2)
      begin
         ref_in = 1'b1;
         repeat (3) @(negedge clk);
         ref_in = 1'b0;
         repeat (3) @(negedge clk);
      end
      repeat (3) @(negedge clk);
   endtask : tick

   task end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial
   begin
      #900us;
      failures++;
      end_of_test;
   end

   initial
   begin
      int b;
      sys_rst = 1'b1;
      chip_enable = 1'b1;
      ref_in = 1'b0;
      fb_in = 1'b0;
      phase_err_small = 1'b0;
      phase_err_large = 1'b0;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk);
      chk(powered_down, 1'b0);
      wr(REF_W);
      chk({pulse_width_bits, band_clock_div_bits, factory_test_bit},
          {2'h2, 2'h1, 1'b1});
      b = refs;
      tick;
      tick;
      chk(24'(refs - b), 24'h2);
      wr(CTL_W);
      chk({prescale_select_bits, core_bias_bits, mux_select_bits,
           output_level_bits, pump_current, pump_polarity, pump_tristate},
          {2'h1, 2'h3, 3'h5, 2'h2, 3'h3, 1'b1, 1'b0});
      #600us;
      b = bands;
      wr(N_W);
      chk({div2_select, div2_enable, main_count_invalid, pump_current},
          {1'b0, 1'b1, 1'b0, 3'h6});
      chk(24'(bands - b), 24'h1);
      wr(CTL_W);
      chk(pump_current, 3'h3);
      chk(24'(bands - b), 24'h1);
      wr(24'h600202);
      chk(main_count_invalid, 1'b1);
      wr(N_W);
      wr(CTL_W | 24'h000200);
      chk(pump_tristate, 1'b1);
      wr(CTL_W);
      chk(pump_tristate, 1'b0);
      i_psl_host_model.send(CTL_W & ~24'h000100, 1'b0);
      chk(pump_polarity, 1'b1);
      wr(24'h4ce0af);
      chk(pump_polarity, 1'b1);
      b = bands;
      wr(CTL_W | 24'h100000);
      chk({powered_down, pump_tristate, rf_output_enable,
           ref_buffer_enable, counters_held, lock_detect},
          6'b110010);
      // Only the control latch is touched while down
      wr(24'h5ce0ac);
      chk(pump_polarity, 1'b0);
      wr(CTL_W);
      chk(powered_down, 1'b0);
      chk(24'(bands - b), 24'h0);
      wr(CTL_W | 24'h300000);
      chk(powered_down, 1'b0);
      tick;
      chk(powered_down, 1'b0);
      tick;
      chk(powered_down, 1'b1);
      wr(CTL_W);
      chip_enable = 1'b0;
      repeat (6) @(negedge clk);
      chk({powered_down, rf_output_enable}, 2'b10);
      chip_enable = 1'b1;
      repeat (6) @(negedge clk);
      chk(powered_down, 1'b0);
      wr(CTL_W | 24'h000010);
      b = refs;
      tick;
      chk(counters_held, 1'b1);
      chk(24'(refs - b), 24'h0);
      wr(CTL_W | 24'h000800);
      chk(rf_output_enable, 1'b0);
      for (int win = 0; win < 2; win++)
      begin
         wr(win ? REF_W | 24'h040000 : REF_W);
         phase_err_large = 1'b1;
         tick;
         chk(lock_detect, 1'b0);
         phase_err_large = 1'b0;
         phase_err_small = 1'b1;
         for (int k = 1; k <= 5; k++)
         begin
            tick;
            chk(lock_detect, k >= (win ? 5 : 3));
            chk(rf_output_enable, k >= (win ? 5 : 3));
         end
         phase_err_small = 1'b0;
      end
      // Swallow 2, main 3: reload through the clear bit, then count
      wr(24'h00030a);
      wr(CTL_W | 24'h000010);
      chk(prescale_modulus, 1'b0);
      wr(CTL_W);
      chk(prescale_modulus, 1'b1);
      b = ns;
      for (int k = 1; k <= 3; k++)
      begin
         fb_in = 1'b1;
         repeat (3) @(negedge clk);
         fb_in = 1'b0;
         repeat (3) @(negedge clk);
         chk(prescale_modulus, k != 2);
      end
      chk(24'(ns - b), 24'h1);
      end_of_test;
   end
endmodule : tb_psl_latch_ctrl
`default_nettype wire
